// ===== shared/apc_pkg.sv
// Shared constants and carrier types for the amplifier protection controller.
`default_nettype none
package apc_pkg;

  // Timing base: 10 MHz core clock.
  localparam int CLOCK_KHZ = 10_000;
  localparam int STEPS_PER_DB = 4;
  localparam int ATTACK_MS_PER_DB = 1200;
  localparam int RELEASE_MS_PER_DB = 2400;
  localparam int DC_HOLD_MS = 420;
  localparam int STARTUP_MS = 20;
  localparam int ATTACK_CYCLES = ATTACK_MS_PER_DB * CLOCK_KHZ / STEPS_PER_DB;
  localparam int RELEASE_CYCLES = RELEASE_MS_PER_DB * CLOCK_KHZ / STEPS_PER_DB;
  localparam int DC_CYCLES = DC_HOLD_MS * CLOCK_KHZ;
  localparam int STARTUP_CYCLES = STARTUP_MS * CLOCK_KHZ;
  localparam int CNT_W = 23;

  // Foldback depth, in 0.25 dB steps.
  localparam int ATTEN_W = 6;
  localparam logic [ATTEN_W-1:0] MAX_ATTEN = 6'h30;

  localparam int CHANNELS = 2;
  localparam int PIN_W = 12;

  // Register byte offsets.
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_ATTEN = 4'h8;
  localparam logic [3:0] OFS_DCERR = 4'hC;

  // Field positions.
  localparam int CTRL_SOFT_MUTE = 0;
  localparam int ST_OUT_LSB = 0;
  localparam int ST_UV = 2;
  localparam int ST_OTP = 3;
  localparam int ST_SC = 4;
  localparam int ST_PARALLEL = 5;
  localparam int ST_STARTING = 6;
  localparam int ST_LOW_POWER = 7;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    OUT_PLAY = 2'h0,
    OUT_MUTE = 2'h1,
    OUT_WEAK_LOW = 2'h2,
    OUT_HIZ = 2'h3
  } apc_out_t;

  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_START,
    PWR_RUN
  } apc_pwr_t;

  // Board and analog comparator levels, in pin order.
  typedef struct packed {
    logic parallel_bridge_select;
    logic shutdown_n;
    logic mute;
    logic over_temp;
    logic foldback_hot;
    logic short_circuit;
    logic supply_below_enter;
    logic supply_above_exit;
    logic [CHANNELS-1:0] duty_high_pos;
    logic [CHANNELS-1:0] duty_high_neg;
  } apc_pins_t;

  localparam apc_pins_t PINS_RESET = 12'h000;

endpackage : apc_pkg
`default_nettype wire

// ===== rtl/apc_sync.sv
// Three-stage input synchroniser with agreement filter, one lane per bit.
`timescale 1ns/10ps
`default_nettype none
module apc_sync
  import apc_pkg::*;
(
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Asynchronous levels in, filtered levels out.
  input wire logic [PIN_W-1:0] i_async,
  output logic [PIN_W-1:0] o_stable
);

  logic [PIN_W-1:0] s1_reg;
  logic [PIN_W-1:0] s2_reg;
  logic [PIN_W-1:0] s3_reg;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_reg <= PINS_RESET;
      s2_reg <= PINS_RESET;
      s3_reg <= PINS_RESET;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A lane only moves once the second and third stages agree.
  genvar g;
  generate
    for (g = 0; g < PIN_W; g++) begin : g_lane
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_stable[g] <= PINS_RESET[g];
        end else if (s2_reg[g] == s3_reg[g]) begin
          o_stable[g] <= s3_reg[g];
        end
      end
    end
  endgenerate

endmodule : apc_sync
`default_nettype wire

// ===== rtl/apc_ctrl.sv
// Mode select, start-up sequencing and fault protection of the amplifier.
// Functional notes
// - High select parallels both channels; low gives two bridges.
// - Parallel mode feeds outputs from channel A only.
// - Shutdown low mutes and enters low power.
// - Mute high grounds outputs through resistive path.
// - Over-temperature forces outputs weak low.
// - Hot die lowers gain 0.25 dB per 300 ms.
// - Cool die restores gain 0.25 dB per 600 ms.
// - Foldback only attenuates, capped, never shuts down.
// - Duty above 60% same polarity 420 ms flags error.
// - Short circuit latches and outputs go high impedance.
// - Undervoltage has enter and higher exit level.
// - Start-up sequence runs after undervoltage release.
`timescale 1ns/10ps
`default_nettype none
module apc_ctrl
  import apc_pkg::*;
#(
  parameter int ATTACK_CYC = ATTACK_CYCLES,
  parameter int RELEASE_CYC = RELEASE_CYCLES,
  parameter int DC_CYC = DC_CYCLES,
  parameter int STARTUP_CYC = STARTUP_CYCLES
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Board pins and analog comparator levels.
  input wire apc_pins_t i_pins,
  // Avalon-MM register slave.
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Power stage control.
  output apc_out_t o_out_state,
  output logic o_parallel_bridge_select,
  output logic o_source_a_only,
  output logic o_low_power,
  output logic [ATTEN_W-1:0] o_gain_atten,
  output logic o_dc_error_event
);

  apc_pins_t pins_q;
  apc_pwr_t pwr_reg;
  logic [CNT_W-1:0] start_cnt_reg;
  logic uv_reg;
  logic sc_latch_reg;
  logic [ATTEN_W-1:0] atten_reg;
  logic [CNT_W-1:0] fb_cnt_reg;
  logic fb_hot_last_reg;
  logic [CHANNELS-1:0] dc_err_reg;
  logic [CHANNELS-1:0] dc_hit;
  logic soft_mute_reg;
  apc_out_t out_next;
  logic wr_taken;
  logic [CHANNELS-1:0] dc_clear;

  apc_sync u_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async (i_pins),
    .o_stable (pins_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register slave: one wait cycle, then the answer at the release edge.
  assign wr_taken = i_avs_write && !o_avs_waitrequest;
  assign dc_clear = (wr_taken && i_avs_address == OFS_DCERR &&
                     i_avs_byteenable[0]) ?
                    i_avs_writedata[CHANNELS-1:0] : '0;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
    end else if (o_avs_waitrequest) begin
      o_avs_waitrequest <= !(i_avs_read || i_avs_write);
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_readdata <= READ_ZERO;
    end else if (i_avs_read && o_avs_waitrequest) begin
      unique case (i_avs_address)
        OFS_CTRL: o_avs_readdata <= {31'h0000_0000, soft_mute_reg};
        OFS_STATUS: o_avs_readdata <= {24'h00_0000, o_low_power,
            pwr_reg == PWR_START, o_parallel_bridge_select, sc_latch_reg,
            pins_q.over_temp, uv_reg, o_out_state};
        OFS_ATTEN: o_avs_readdata <= {26'h000_0000, atten_reg};
        OFS_DCERR: o_avs_readdata <= {30'h0000_0000, dc_err_reg};
        default: o_avs_readdata <= READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      soft_mute_reg <= CTRL_RESET[CTRL_SOFT_MUTE];
    end else if (wr_taken && i_avs_address == OFS_CTRL &&
                 i_avs_byteenable[0]) begin
      soft_mute_reg <= i_avs_writedata[CTRL_SOFT_MUTE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode select and power sequencing.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_parallel_bridge_select <= 1'b0;
      o_source_a_only <= 1'b0;
    end else begin
      o_parallel_bridge_select <= pins_q.parallel_bridge_select;
      o_source_a_only <= pins_q.parallel_bridge_select;
    end
  end

  // Exit needs the higher level, so a supply hovering between the two
  // levels cannot chatter the outputs.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      uv_reg <= 1'b1;
    end else if (pins_q.supply_below_enter) begin
      uv_reg <= 1'b1;
    end else if (pins_q.supply_above_exit) begin
      uv_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwr_reg <= PWR_OFF;
      start_cnt_reg <= '0;
    end else if (!pins_q.shutdown_n || uv_reg) begin
      pwr_reg <= PWR_OFF;
      start_cnt_reg <= '0;
    end else begin
      unique case (pwr_reg)
        PWR_OFF: pwr_reg <= PWR_START;
        PWR_START: begin
          if (start_cnt_reg == CNT_W'(STARTUP_CYC - 1)) begin
            pwr_reg <= PWR_RUN;
          end else begin
            start_cnt_reg <= start_cnt_reg + 1'b1;
          end
        end
        PWR_RUN: start_cnt_reg <= '0;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_low_power <= 1'b1;
    end else begin
      o_low_power <= !pins_q.shutdown_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Short-circuit latch: a fresh short wins over the shutdown clear.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sc_latch_reg <= 1'b0;
    end else if (pins_q.short_circuit) begin
      sc_latch_reg <= 1'b1;
    end else if (!pins_q.shutdown_n) begin
      sc_latch_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thermal foldback: the step timer restarts whenever the direction flips.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      atten_reg <= '0;
      fb_cnt_reg <= '0;
      fb_hot_last_reg <= 1'b0;
    end else begin
      fb_hot_last_reg <= pins_q.foldback_hot;
      if (pins_q.foldback_hot != fb_hot_last_reg) begin
        fb_cnt_reg <= '0;
      end else if (pins_q.foldback_hot) begin
        if (fb_cnt_reg == CNT_W'(ATTACK_CYC - 1)) begin
          fb_cnt_reg <= '0;
          if (atten_reg != MAX_ATTEN) begin
            atten_reg <= atten_reg + 1'b1;
          end
        end else begin
          fb_cnt_reg <= fb_cnt_reg + 1'b1;
        end
      end else if (atten_reg != '0) begin
        if (fb_cnt_reg == CNT_W'(RELEASE_CYC - 1)) begin
          fb_cnt_reg <= '0;
          atten_reg <= atten_reg - 1'b1;
        end else begin
          fb_cnt_reg <= fb_cnt_reg + 1'b1;
        end
      end else begin
        fb_cnt_reg <= '0;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_gain_atten <= '0;
    end else begin
      o_gain_atten <= atten_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DC detection per channel; a polarity swap restarts the count.
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_dc
      logic [CNT_W-1:0] cnt_reg;
      logic pol_reg;
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          cnt_reg <= '0;
          pol_reg <= 1'b0;
        end else if (pins_q.duty_high_pos[ch] == pins_q.duty_high_neg[ch]) begin
          cnt_reg <= '0;
        end else if (pins_q.duty_high_pos[ch] != pol_reg) begin
          pol_reg <= pins_q.duty_high_pos[ch];
          cnt_reg <= CNT_W'(1);
        end else if (cnt_reg != CNT_W'(DC_CYC)) begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
      assign dc_hit[ch] = (cnt_reg == CNT_W'(DC_CYC));
      // Hardware set wins over a software clear in the same cycle.
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          dc_err_reg[ch] <= 1'b0;
        end else if (dc_hit[ch]) begin
          dc_err_reg[ch] <= 1'b1;
        end else if (dc_clear[ch]) begin
          dc_err_reg[ch] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dc_error_event <= 1'b0;
    end else begin
      o_dc_error_event <= |dc_err_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output state priority. Shutdown mutes at once, without waiting for the
  // power sequencer to leave the run state a cycle later.
  always_comb begin
    if (sc_latch_reg) begin
      out_next = OUT_HIZ;
    end else if (pins_q.over_temp || uv_reg) begin
      out_next = OUT_WEAK_LOW;
    end else if (pins_q.mute || soft_mute_reg || !pins_q.shutdown_n ||
                 pwr_reg != PWR_RUN) begin
      out_next = OUT_MUTE;
    end else begin
      out_next = OUT_PLAY;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out_state <= OUT_MUTE;
    end else begin
      o_out_state <= out_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  parallel_source_a: assert property (
    pins_q.parallel_bridge_select |=> o_source_a_only && o_parallel_bridge_select)
    else $error("parallel mode not sourcing channel A");
  shutdown_quiet_a: assert property (
    !pins_q.shutdown_n |=> o_low_power && o_out_state != OUT_PLAY)
    else $error("shutdown did not silence outputs");
  mute_ground_a: assert property (
    pins_q.mute && !sc_latch_reg && !pins_q.over_temp && !uv_reg
      |=> o_out_state == OUT_MUTE)
    else $error("mute input did not mute");
  otp_weak_low_a: assert property (
    pins_q.over_temp && !sc_latch_reg |=> o_out_state == OUT_WEAK_LOW)
    else $error("over-temperature did not force weak low");
  attack_cause_a: assert property (
    atten_reg > $past(atten_reg) |-> $past(pins_q.foldback_hot, 2))
    else $error("attenuation grew while die cool");
  release_cause_a: assert property (
    atten_reg < $past(atten_reg) |-> !$past(pins_q.foldback_hot, 2))
    else $error("gain restored while die hot");
  atten_cap_a: assert property (
    atten_reg <= MAX_ATTEN && (atten_reg == $past(atten_reg) ||
      atten_reg == $past(atten_reg) + 1'b1 ||
      atten_reg == $past(atten_reg) - 1'b1))
    else $error("attenuation out of range or jumped");
  dc_flag_a: assert property (
    $rose(dc_err_reg[0]) |-> $past(dc_hit[0]))
    else $error("dc error without full hold time");
  short_hiz_a: assert property (
    pins_q.short_circuit |-> ##2 o_out_state == OUT_HIZ)
    else $error("short circuit did not reach high impedance");
  uv_exit_a: assert property (
    $fell(uv_reg) |-> $past(pins_q.supply_above_exit)
      && !$past(pins_q.supply_below_enter))
    else $error("undervoltage left below exit level");
  startup_bound_a: assert property (
    pwr_reg == PWR_START |-> start_cnt_reg < CNT_W'(STARTUP_CYC))
    else $error("start-up overran its time");
  priority_hiz_a: assert property (
    sc_latch_reg |=> o_out_state == OUT_HIZ)
    else $error("short latch lost output priority");
  latch_hold_a: assert property (
    sc_latch_reg && pins_q.shutdown_n |=> sc_latch_reg)
    else $error("short latch cleared without shutdown");

endmodule : apc_ctrl
`default_nettype wire

// ===== tb/apc_board_model.sv
// Board-side model: control pins, supply comparators and fault sensors.
`timescale 1ns/10ps
`default_nettype none
module apc_board_model
  import apc_pkg::*;
(
  // Clock.
  input wire logic i_clock,
  // Requested board levels.
  input wire logic i_shutdown_req_n,
  input wire logic [1:0] i_supply_lvl,
  input wire apc_pins_t i_sense,
  // Pins to the device.
  output apc_pins_t o_pins
);
  logic [1:0] supply_reg = 2'b01;
  logic [3:0] gap_reg = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // A supply change is wrapped in a shutdown window, so the rail moves only
  // while the amplifier is parked; this keeps pops down on real boards.
  always_ff @(posedge i_clock) begin
    if (i_supply_lvl != supply_reg && gap_reg == 4'h0) begin
      gap_reg <= 4'h8;
    end else if (gap_reg != 4'h0) begin
      gap_reg <= gap_reg - 4'h1;
    end
    if (gap_reg == 4'h4) begin
      supply_reg <= i_supply_lvl;
    end
  end

  always_comb begin
    o_pins = i_sense;
    o_pins.shutdown_n = i_shutdown_req_n && (gap_reg == 4'h0);
    o_pins.supply_below_enter = supply_reg[1];
    o_pins.supply_above_exit = supply_reg[0];
  end
endmodule : apc_board_model
`default_nettype wire

// ===== tb/tb_apc_ctrl.sv
// Self-checking testbench of the amplifier protection controller.
`timescale 1ns/10ps
`default_nettype none
module tb_apc_ctrl;
  import apc_pkg::*;
  logic i_clock, rst_n, sd_req_n, rd, wr, wait_req, par, src_a, low_pwr, dc_ev;
  logic [1:0] supply_lvl;
  logic [3:0] addr, be;
  logic [31:0] wdata, rdata, d;
  logic [ATTEN_W-1:0] atten;
  apc_pins_t sense, pins;
  apc_out_t out_st;
  int n_errors = 0;
  int num_checks = 0;

  apc_board_model board (.i_clock(i_clock), .i_shutdown_req_n(sd_req_n),
    .i_supply_lvl(supply_lvl), .i_sense(sense), .o_pins(pins));
  apc_ctrl #(.ATTACK_CYC(8), .RELEASE_CYC(16), .DC_CYC(10), .STARTUP_CYC(6))
    dut (.i_clock(i_clock), .i_rst_n(rst_n), .i_pins(pins),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .o_out_state(out_st),
    .o_parallel_bridge_select(par), .o_source_a_only(src_a),
    .o_low_power(low_pwr), .o_gain_atten(atten), .o_dc_error_event(dc_ev));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  // Sampling right after the edge reads pre-edge values, as a bus would.
  task automatic bus(input logic wr_n_rd, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    addr <= a;
    wdata <= wd;
    wr <= wr_n_rd;
    rd <= ~wr_n_rd;
    @(posedge i_clock);
    // Ends when waitrequest drops; only the watchdog stops a slave that never releases.
    while (wait_req !== 1'b0) begin
      @(posedge i_clock);
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge i_clock);
  endtask : bus

  // Waits, with a bound, for out state (0), attenuation (1) or dc flag (2).
  task automatic wait_val(input int sel, input logic [7:0] exp, input int max);
    logic [7:0] v;
    int n;
    n = 0;
    v = 8'h00;
    while (n <= max) begin
      @(posedge i_clock);
      v = (sel == 0) ? 8'(out_st) : (sel == 1) ? 8'(atten) : 8'(dc_ev);
      if (v === exp) break;
      n++;
    end
    chk(32'(v), 32'(exp));
  endtask : wait_val

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge i_clock);
    n_errors++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    sd_req_n = 1'b1;
    supply_lvl = 2'b01;
    sense = PINS_RESET;
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0000_0000;
    be = 4'h1;
    repeat (12) @(posedge i_clock);
    chk(32'(out_st), 32'(OUT_MUTE));
    rst_n <= 1'b1;
    wait_val(0, 8'(OUT_PLAY), 40);
    chk(32'(low_pwr), 32'h0000_0000);
    $display("test startup done");
    // Mode select in both directions.
    for (int m = 1; m >= 0; m--) begin
      sense.parallel_bridge_select <= m[0];
      repeat (8) @(posedge i_clock);
      chk(32'(par), 32'(m));
      chk(32'(src_a), 32'(m));
      bus(1'b0, OFS_STATUS, 32'h0000_0000, d);
      chk(32'(d[ST_PARALLEL]), 32'(m));
    end
    $display("test mode done");
    sense.mute <= 1'b1;
    wait_val(0, 8'(OUT_MUTE), 10);
    sense.over_temp <= 1'b1;
    wait_val(0, 8'(OUT_WEAK_LOW), 10);
    sense.mute <= 1'b0;
    sense.over_temp <= 1'b0;
    wait_val(0, 8'(OUT_PLAY), 10);
    bus(1'b1, OFS_CTRL, 32'h0000_0001, d);
    bus(1'b0, OFS_CTRL, 32'h0000_0000, d);
    chk(d, 32'h0000_0001);
    wait_val(0, 8'(OUT_MUTE), 4);
    bus(1'b1, OFS_CTRL, 32'h0000_0000, d);
    wait_val(0, 8'(OUT_PLAY), 4);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF, d);
    bus(1'b0, 4'h2, 32'h0000_0000, d);
    chk(d, READ_ZERO);
    // A write with lane 0 disabled must leave the control register alone.
    be <= 4'h0;
    bus(1'b1, OFS_CTRL, 32'h0000_0001, d);
    be <= 4'h1;
    bus(1'b0, OFS_CTRL, 32'h0000_0000, d);
    chk(d, CTRL_RESET);
    chk(32'(out_st), 32'(OUT_PLAY));
    $display("test mute done");
    sense.foldback_hot <= 1'b1;
    wait_val(1, 8'h01, 20);
    repeat (32) @(posedge i_clock);
    chk(32'(atten), 32'h0000_0005);
    repeat (400) @(posedge i_clock);
    chk(32'(atten), 32'(MAX_ATTEN));
    chk(32'(out_st), 32'(OUT_PLAY));
    sense.foldback_hot <= 1'b0;
    wait_val(1, 8'h2F, 30);
    repeat (64) @(posedge i_clock);
    chk(32'(atten), 32'h0000_002B);
    wait_val(1, 8'h00, 760);
    repeat (40) @(posedge i_clock);
    bus(1'b0, OFS_ATTEN, 32'h0000_0000, d);
    chk(d, 32'h0000_0000);
    $display("test foldback done");
    for (int c = 0; c < CHANNELS; c++) begin
      if (c == 0) sense.duty_high_pos[0] <= 1'b1;
      else sense.duty_high_neg[1] <= 1'b1;
      repeat (8) @(posedge i_clock);
      chk(32'(dc_ev), 32'h0000_0000);
      wait_val(2, 8'h01, 15);
      sense.duty_high_pos <= '0;
      sense.duty_high_neg <= '0;
      repeat (8) @(posedge i_clock);
      bus(1'b0, OFS_DCERR, 32'h0000_0000, d);
      chk(d, 32'(1 << c));
      bus(1'b1, OFS_DCERR, 32'h0000_0003, d);
      bus(1'b0, OFS_DCERR, 32'h0000_0000, d);
      chk(d, 32'h0000_0000);
      chk(32'(dc_ev), 32'h0000_0000);
    end
    $display("test dc done");
    sense.short_circuit <= 1'b1;
    sense.over_temp <= 1'b1;
    wait_val(0, 8'(OUT_HIZ), 10);
    sense.short_circuit <= 1'b0;
    sense.over_temp <= 1'b0;
    repeat (20) @(posedge i_clock);
    chk(32'(out_st), 32'(OUT_HIZ));
    sd_req_n <= 1'b0;
    wait_val(0, 8'(OUT_MUTE), 10);
    chk(32'(low_pwr), 32'h0000_0001);
    bus(1'b0, OFS_STATUS, 32'h0000_0000, d);
    chk(32'(d[ST_LOW_POWER]), 32'h0000_0001);
    chk(32'(d[ST_SC]), 32'h0000_0000);
    sd_req_n <= 1'b1;
    wait_val(0, 8'(OUT_PLAY), 30);
    $display("test short done");
    supply_lvl <= 2'b10;
    wait_val(0, 8'(OUT_WEAK_LOW), 20);
    supply_lvl <= 2'b00;
    repeat (30) @(posedge i_clock);
    chk(32'(out_st), 32'(OUT_WEAK_LOW));
    supply_lvl <= 2'b01;
    wait_val(0, 8'(OUT_PLAY), 50);
    $display("test undervoltage done");
    print_verdict();
  end
endmodule : tb_apc_ctrl
`default_nettype wire
